// *** design/rsn_pkg.sv ***
// constants, field positions and carrier types of the reset status block
// assumes one system clock and a 32-bit avalon-mm register port
// How it works
// - deadman bit 5, watchdog bit 4 set
// - sleep bit 3, idle bit 2 set
// - brownout bit 1, power-up bit 0
// - cause flags stay until software clears
// - unlocked write 1 arms soft reset, hardware clears
// - read while armed issues the reset
// - deadman nmi flag bit 25, starts counter
// - watchdog nmi flag bit 24, starts counter
// - writing 1 at bit 23 raises nmi
// - general nmi bit 19 or key raises
// - monitor config 0b11 clock fail sets bit 17
// - clock fail flag set raises nmi only
// - clock switch done clears clock fail flag
// - watchdog in sleep sets bit 16
// - bits 15-0 hold counter reload value
// - counter loads, decrements, zero issues reset
// - only watchdog and deadman start counter
// - reload zero resets without delay
// - unimplemented bits read as zero
// - standby bit keeps regulator on in sleep
`default_nettype none

package rsn_pkg;

	// ---------------------------------------------------------------
	// register map, byte addresses
	// ---------------------------------------------------------------
	localparam int RSN_AW = 8;
	localparam logic [7:0] RSN_OFS_CAUSE = 8'h40;
	localparam logic [7:0] RSN_OFS_SOFT_RESET_ARM = 8'h50;
	localparam logic [7:0] RSN_OFS_NMI = 8'h60;
	localparam logic [7:0] RSN_OFS_PWR = 8'h70;
	localparam logic [7:0] RSN_OFS_KEY = 8'h80;
	localparam logic [7:0] RSN_OFS_UNLOCK = 8'h90;

	// ---------------------------------------------------------------
	// field positions
	// ---------------------------------------------------------------
	localparam int RSN_B_POR = 0;
	localparam int RSN_B_BOR = 1;
	localparam int RSN_B_IDLE = 2;
	localparam int RSN_B_SLEEP = 3;
	localparam int RSN_B_WATCHDOG_TIMEOUT_FLAG = 4;
	localparam int RSN_B_DEADMAN_TIMEOUT_FLAG = 5;
	localparam int RSN_B_WATCHDOG_SLEEP_FLAG = 16;
	localparam int RSN_B_CF = 17;
	localparam int RSN_B_GENERAL_NMI_FLAG = 19;
	localparam int RSN_B_SOFTWARE_NMI_TRIGGER = 23;
	localparam int RSN_B_NWDTO = 24;
	localparam int RSN_B_NDMTO = 25;
	localparam int RSN_B_SOFT_RESET_ARM = 0;
	localparam int RSN_B_REGULATOR_STANDBY_SELECT = 0;
	localparam int RSN_B_UNLOCKED = 0;
	localparam int RSN_B_CNT_BUSY = 1;
	localparam int RSN_KEY_LSB = 24;
	localparam int RSN_CNT_W = 16;

	// ---------------------------------------------------------------
	// reset values, masks, keys
	// ---------------------------------------------------------------
	localparam logic [31:0] RSN_CAUSE_RST = 32'h0000_0003;
	localparam logic [31:0] RSN_CAUSE_MASK = 32'h0000_003F;
	localparam logic [31:0] RSN_NMI_MASK = 32'h038B_FFFF;
	localparam logic [31:0] RSN_PWR_MASK = 32'h0000_0001;
	localparam logic [31:0] RSN_ZERO = 32'h0000_0000;
	localparam logic [7:0] RSN_NMI_KEY = 8'h4E;
	// unlock keys: values are arbitrary
	localparam logic [31:0] RSN_UNLOCK_KEY1 = 32'hC3A5_0F1E;
	localparam logic [31:0] RSN_UNLOCK_KEY2 = 32'h3C5A_F0E1;
	localparam logic [1:0] RSN_CLOCK_FAIL_MONITOR_ON = 2'h3;

	// ---------------------------------------------------------------
	// types
	// ---------------------------------------------------------------
	typedef struct packed {
		logic wdt_timeout;
		logic dmt_timeout;
		logic in_sleep;
		logic in_idle;
		logic clock_fail;
		logic clk_switch_done;
		logic general_nmi_flag_event;
	} rsn_evt_s;

	typedef enum logic [0:0] {
		RSN_CNT_IDLE = 1'b0,
		RSN_CNT_RUN = 1'b1
	} rsn_cnt_e;

endpackage

`default_nettype wire

// *** design/rsn_sync2.sv ***
// two-flop synchroniser for levels from outside the clock domain
// assumes slowly changing levels; pulses must last two clocks or more
`default_nettype none

module rsn_sync2 #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	input wire logic ce_i,
	// data
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	import rsn_pkg::*;

	logic [W-1:0] meta_ff;

	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_b_i)
		begin
			meta_ff <= '0;
			q_o <= '0;
		end
		else if (ce_i)
		begin
			meta_ff <= d_i;
			q_o <= meta_ff;
		end
	end

endmodule

`default_nettype wire

// *** design/rsn_nmi_counter.sv ***
// delayed reset counter started by watchdog and deadman nmis
// assumes start is a one-cycle pulse on the system clock
`default_nettype none

module rsn_nmi_counter #(
	parameter int W = 16
) (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	input wire logic ce_i,
	// control
	input wire logic start_i,
	input wire logic stop_i,
	input wire logic [W-1:0] reload_i,
	// status
	output logic busy_o,
	output logic expire_o
);
	import rsn_pkg::*;

	rsn_cnt_e state_ff;
	logic [W-1:0] count_ff;

	assign busy_o = (state_ff == RSN_CNT_RUN);

	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_b_i)
		begin
			state_ff <= RSN_CNT_IDLE;
			count_ff <= '0;
			expire_o <= 1'b0;
		end
		else if (ce_i)
		begin
			expire_o <= 1'b0;
			if (stop_i)
			begin
				state_ff <= RSN_CNT_IDLE;
			end
			// zero reload is fired by the parent with the nmi; stay idle
			else if (start_i && reload_i == '0)
			begin
				state_ff <= RSN_CNT_IDLE;
			end
			// a restart reloads; a second nmi restarts the full reload delay
			else if (start_i)
			begin
				state_ff <= RSN_CNT_RUN;
				count_ff <= reload_i - W'(1);
				expire_o <= (reload_i == W'(1));
				if (reload_i == W'(1))
					state_ff <= RSN_CNT_IDLE;
			end
			else
			begin
				unique case (state_ff)
					RSN_CNT_IDLE:
						count_ff <= count_ff;
					RSN_CNT_RUN:
					begin
						count_ff <= count_ff - W'(1);
						if (count_ff == W'(1))
						begin
							state_ff <= RSN_CNT_IDLE;
							expire_o <= 1'b1;
						end
					end
				endcase
			end
		end
	end

endmodule

`default_nettype wire

// *** design/rsn_reset_status.sv ***
// reset cause flags, software reset and nmi control with delayed reset
// assumes event inputs come from logic on ref_clk_i; brownout and
// monitor configuration arrive asynchronously and are synchronised
`default_nettype none

module rsn_reset_status (
	// clock, reset, enable
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	input wire logic ce_i,
	// avalon-mm slave
	input wire logic [rsn_pkg::RSN_AW-1:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// event sources
	input wire rsn_pkg::rsn_evt_s evt_i,
	input wire logic bor_event_i,
	input wire logic [1:0] clock_monitor_config_i,
	// requests out
	output logic nmi_req_o,
	output logic sysrst_req_o,
	output logic regulator_standby_o
);
	import rsn_pkg::*;

	// ---------------------------------------------------------------
	// declarations
	// ---------------------------------------------------------------
	logic [31:0] reset_cause_status_ff;
	logic [31:0] nmi_control_counter_ff;
	logic [31:0] power_control_ff;
	logic [31:0] nxt_cause;
	logic [31:0] nxt_nmi;
	logic [31:0] wmask;
	logic [31:0] nxt_rdata;
	logic unlock_stage_ff;
	logic unlocked_ff;
	logic soft_reset_arm_ff;
	logic bor_q;
	logic [1:0] cfg_q;
	logic req;
	logic acc;
	logic wr;
	logic rd;
	logic wr_cause;
	logic wr_soft_reset_arm;
	logic rd_soft_reset_arm;
	logic wr_nmi;
	logic wr_pwr;
	logic wr_key;
	logic wr_unlock;
	logic key_hit;
	logic sw_dmt;
	logic sw_wdt;
	logic sw_watchdog_sleep_flag;
	logic sw_cf;
	logic sw_general_nmi_flag;
	logic sw_software_nmi_trigger;
	logic hw_wdt_run;
	logic hw_wdt_sleep;
	logic hw_cf;
	logic cnt_start;
	logic cnt_busy;
	logic cnt_expire;
	logic soft_fire;
	logic any_nmi;
	logic zero_fire;

	// ---------------------------------------------------------------
	// input synchronisers
	// ---------------------------------------------------------------
	rsn_sync2 #(.W(1)) u_bor_sync (
		.ref_clk_i(ref_clk_i),
		.rst_b_i(rst_b_i),
		.ce_i(ce_i),
		.d_i(bor_event_i),
		.q_o(bor_q)
	);

	rsn_sync2 #(.W(2)) u_cfg_sync (
		.ref_clk_i(ref_clk_i),
		.rst_b_i(rst_b_i),
		.ce_i(ce_i),
		.d_i(clock_monitor_config_i),
		.q_o(cfg_q)
	);

	// ---------------------------------------------------------------
	// bus slave
	// ---------------------------------------------------------------
	// every access takes two cycles: waitrequest drops for one cycle
	assign req = avs_read_i || avs_write_i;
	assign acc = ce_i && req && !avs_waitrequest_o;
	assign wr = acc && avs_write_i;
	assign rd = acc && avs_read_i;
	assign wr_cause = wr && avs_address_i == RSN_OFS_CAUSE;
	assign wr_soft_reset_arm = wr && avs_address_i == RSN_OFS_SOFT_RESET_ARM;
	assign rd_soft_reset_arm = rd && avs_address_i == RSN_OFS_SOFT_RESET_ARM;
	assign wr_nmi = wr && avs_address_i == RSN_OFS_NMI;
	assign wr_pwr = wr && avs_address_i == RSN_OFS_PWR;
	assign wr_key = wr && avs_address_i == RSN_OFS_KEY;
	assign wr_unlock = wr && avs_address_i == RSN_OFS_UNLOCK;

	genvar gb;
	generate
		for (gb = 0; gb < 4; gb++)
		begin : g_lane
			assign wmask[gb*8 +: 8] = {8{avs_byteenable_i[gb]}};
		end
	endgenerate

	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_b_i)
			avs_waitrequest_o <= 1'b1;
		else if (ce_i)
			avs_waitrequest_o <= !(req && avs_waitrequest_o);
	end

	always_comb
	begin
		nxt_rdata = RSN_ZERO;
		unique case (avs_address_i)
			RSN_OFS_CAUSE:
				nxt_rdata = reset_cause_status_ff & RSN_CAUSE_MASK;
			RSN_OFS_NMI:
				nxt_rdata = nmi_control_counter_ff & RSN_NMI_MASK;
			RSN_OFS_PWR:
				nxt_rdata = power_control_ff & RSN_PWR_MASK;
			RSN_OFS_UNLOCK:
			begin
				nxt_rdata[RSN_B_UNLOCKED] = unlocked_ff;
				nxt_rdata[RSN_B_CNT_BUSY] = cnt_busy;
			end
			default:
				nxt_rdata = RSN_ZERO;
		endcase
	end

	// data is loaded one edge before the accepting edge
	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_b_i)
			avs_readdata_o <= RSN_ZERO;
		else if (ce_i && avs_read_i && avs_waitrequest_o)
			avs_readdata_o <= nxt_rdata;
	end

	// ---------------------------------------------------------------
	// reset cause flags
	// ---------------------------------------------------------------
	always_comb
	begin
		nxt_cause = reset_cause_status_ff;
		if (wr_cause)
			nxt_cause = ((reset_cause_status_ff & ~wmask) |
				(avs_writedata_i & wmask)) & RSN_CAUSE_MASK;
		if (evt_i.dmt_timeout)
			nxt_cause[RSN_B_DEADMAN_TIMEOUT_FLAG] = 1'b1;
		if (evt_i.wdt_timeout)
			nxt_cause[RSN_B_WATCHDOG_TIMEOUT_FLAG] = 1'b1;
		if (evt_i.in_sleep)
			nxt_cause[RSN_B_SLEEP] = 1'b1;
		if (evt_i.in_idle)
			nxt_cause[RSN_B_IDLE] = 1'b1;
		if (bor_q)
			nxt_cause[RSN_B_BOR] = 1'b1;
	end

	// only a write clears; hardware set wins
	// rst_b_i is power-on only, so flags outlive sysrst
	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_b_i)
			reset_cause_status_ff <= RSN_CAUSE_RST;
		else if (ce_i)
			reset_cause_status_ff <= nxt_cause;
	end

	// ---------------------------------------------------------------
	// unlock sequence and software reset
	// ---------------------------------------------------------------
	// any unlock-register write other than the key pair relocks the gate
	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_b_i)
		begin
			unlock_stage_ff <= 1'b0;
			unlocked_ff <= 1'b0;
		end
		else if (ce_i && wr_unlock)
		begin
			unlock_stage_ff <= (avs_writedata_i == RSN_UNLOCK_KEY1);
			unlocked_ff <= unlock_stage_ff &&
				(avs_writedata_i == RSN_UNLOCK_KEY2);
		end
	end

	assign soft_fire = rd_soft_reset_arm && soft_reset_arm_ff;

	// arm on unlocked write of 1, cleared by the reset
	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_b_i)
			soft_reset_arm_ff <= 1'b0;
		else if (ce_i)
		begin
			if (sysrst_req_o)
				soft_reset_arm_ff <= 1'b0;
			else if (wr_soft_reset_arm && unlocked_ff &&
				avs_byteenable_i[0] && avs_writedata_i[RSN_B_SOFT_RESET_ARM])
				soft_reset_arm_ff <= 1'b1;
		end
	end

	// ---------------------------------------------------------------
	// nmi control
	// ---------------------------------------------------------------
	assign sw_dmt = wr_nmi && avs_byteenable_i[3] &&
		avs_writedata_i[RSN_B_NDMTO];
	assign sw_wdt = wr_nmi && avs_byteenable_i[3] &&
		avs_writedata_i[RSN_B_NWDTO];
	assign sw_software_nmi_trigger = wr_nmi && avs_byteenable_i[2] &&
		avs_writedata_i[RSN_B_SOFTWARE_NMI_TRIGGER];
	assign sw_general_nmi_flag = wr_nmi && avs_byteenable_i[2] &&
		avs_writedata_i[RSN_B_GENERAL_NMI_FLAG];
	assign sw_cf = wr_nmi && avs_byteenable_i[2] &&
		avs_writedata_i[RSN_B_CF];
	assign sw_watchdog_sleep_flag = wr_nmi && avs_byteenable_i[2] &&
		avs_writedata_i[RSN_B_WATCHDOG_SLEEP_FLAG];
	assign key_hit = wr_key && avs_byteenable_i[3] &&
		avs_writedata_i[RSN_KEY_LSB +: 8] == RSN_NMI_KEY;
	assign hw_wdt_run = evt_i.wdt_timeout && !evt_i.in_sleep;
	assign hw_wdt_sleep = evt_i.wdt_timeout && evt_i.in_sleep;
	// monitor must be enabled by config
	assign hw_cf = evt_i.clock_fail && cfg_q == RSN_CLOCK_FAIL_MONITOR_ON;

	always_comb
	begin
		nxt_nmi = nmi_control_counter_ff;
		if (wr_nmi)
			nxt_nmi = ((nmi_control_counter_ff & ~wmask) |
				(avs_writedata_i & wmask)) & RSN_NMI_MASK;
		// switch done clears, a new failure still wins
		if (evt_i.clk_switch_done)
			nxt_nmi[RSN_B_CF] = 1'b0;
		if (evt_i.dmt_timeout)
			nxt_nmi[RSN_B_NDMTO] = 1'b1;
		if (hw_wdt_run)
			nxt_nmi[RSN_B_NWDTO] = 1'b1;
		if (hw_wdt_sleep)
			nxt_nmi[RSN_B_WATCHDOG_SLEEP_FLAG] = 1'b1;
		if (evt_i.general_nmi_flag_event || key_hit)
			nxt_nmi[RSN_B_GENERAL_NMI_FLAG] = 1'b1;
		if (hw_cf)
			nxt_nmi[RSN_B_CF] = 1'b1;
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_b_i)
			nmi_control_counter_ff <= RSN_ZERO;
		else if (ce_i)
			nmi_control_counter_ff <= nxt_nmi;
	end

	// software trigger, and every flag write of 1
	// clock fail raises nmi, no oscillator switch here
	assign any_nmi = sw_dmt || sw_wdt || sw_software_nmi_trigger || sw_general_nmi_flag ||
		sw_cf || sw_watchdog_sleep_flag || key_hit || evt_i.dmt_timeout ||
		evt_i.wdt_timeout || evt_i.general_nmi_flag_event || hw_cf;

	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_b_i)
			nmi_req_o <= 1'b0;
		else if (ce_i)
			nmi_req_o <= any_nmi;
	end

	// ---------------------------------------------------------------
	// delayed reset counter
	// ---------------------------------------------------------------
	// only watchdog out of sleep and deadman start it
	assign cnt_start = evt_i.dmt_timeout || hw_wdt_run ||
		sw_dmt || sw_wdt;

	rsn_nmi_counter #(.W(RSN_CNT_W)) u_cnt (
		.ref_clk_i(ref_clk_i),
		.rst_b_i(rst_b_i),
		.ce_i(ce_i),
		.start_i(cnt_start),
		.stop_i(sysrst_req_o),
		.reload_i(nmi_control_counter_ff[RSN_CNT_W-1:0]),
		.busy_o(cnt_busy),
		.expire_o(cnt_expire)
	);

	// zero reload resets together with the nmi
	assign zero_fire = cnt_start &&
		nmi_control_counter_ff[RSN_CNT_W-1:0] == '0;

	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_b_i)
			sysrst_req_o <= 1'b0;
		else if (ce_i)
			sysrst_req_o <= soft_fire || cnt_expire || zero_fire;
	end

	// ---------------------------------------------------------------
	// power control
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_b_i)
			power_control_ff <= RSN_ZERO;
		else if (ce_i && wr_pwr)
			power_control_ff <= ((power_control_ff & ~wmask) |
				(avs_writedata_i & wmask)) & RSN_PWR_MASK;
	end

	// standby only in sleep with the bit clear
	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_b_i)
			regulator_standby_o <= 1'b0;
		else if (ce_i)
			regulator_standby_o <= evt_i.in_sleep &&
				!power_control_ff[RSN_B_REGULATOR_STANDBY_SELECT];
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	chk_wdt_flag_set: assert property (@(posedge ref_clk_i)
		disable iff (!rst_b_i)
		ce_i && evt_i.wdt_timeout |=> reset_cause_status_ff[RSN_B_WATCHDOG_TIMEOUT_FLAG])
		else $error("watchdog cause flag not set");

	chk_sleep_flag_set: assert property (@(posedge ref_clk_i)
		disable iff (!rst_b_i)
		ce_i && evt_i.in_sleep |=> reset_cause_status_ff[RSN_B_SLEEP])
		else $error("sleep cause flag not set");

	chk_bor_flag_set: assert property (@(posedge ref_clk_i)
		disable iff (!rst_b_i)
		ce_i && bor_q |=> reset_cause_status_ff[RSN_B_BOR])
		else $error("brownout flag not set");

	chk_cause_flag_hold: assert property (@(posedge ref_clk_i)
		disable iff (!rst_b_i)
		!wr_cause |=> (reset_cause_status_ff &
		$past(reset_cause_status_ff)) == $past(reset_cause_status_ff))
		else $error("cause flag cleared without a write");

	chk_locked_soft_reset_arm_ignored: assert property (@(posedge ref_clk_i)
		disable iff (!rst_b_i)
		!soft_reset_arm_ff && wr_soft_reset_arm && !unlocked_ff
		|=> !soft_reset_arm_ff)
		else $error("locked soft reset write armed");

	chk_soft_reset_arm_read_fires: assert property (@(posedge ref_clk_i)
		disable iff (!rst_b_i)
		rd_soft_reset_arm && soft_reset_arm_ff |=> sysrst_req_o ##1 !soft_reset_arm_ff)
		else $error("armed read did not reset");

	chk_dmt_nmi_raise: assert property (@(posedge ref_clk_i)
		disable iff (!rst_b_i)
		ce_i && evt_i.dmt_timeout
		|=> nmi_req_o && nmi_control_counter_ff[RSN_B_NDMTO])
		else $error("deadman nmi not raised");

	chk_zero_reload_reset: assert property (@(posedge ref_clk_i)
		disable iff (!rst_b_i)
		ce_i && cnt_start &&
		nmi_control_counter_ff[RSN_CNT_W-1:0] == '0 |=> sysrst_req_o)
		else $error("zero reload did not reset at once");

	chk_general_nmi_flag_no_count: assert property (@(posedge ref_clk_i)
		disable iff (!rst_b_i)
		ce_i && !cnt_busy && !cnt_start |=> !cnt_busy)
		else $error("counter started without watchdog or deadman");

endmodule

`default_nettype wire

// *** test/rsn_far_model.sv ***
// far-side model: watchdog, deadman, clock monitor and sleep/idle levels
// assumes the bench asks for one event at a time through kick_i
`default_nettype none

module rsn_far_model (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	// commands from the bench
	input wire logic kick_i,
	input wire logic [2:0] kind_i,
	input wire logic sleep_i,
	input wire logic idle_i,
	input wire logic bor_i,
	input wire logic [1:0] cfg_i,
	// towards the block
	output var rsn_pkg::rsn_evt_s evt_o,
	output logic bor_o,
	output logic [1:0] cfg_o
);
	timeunit 1ns;
	timeprecision 1ns;
	import rsn_pkg::*;

	// ---------------------------------------------------------------
	// event pulses
	// ---------------------------------------------------------------
	// timer, clock and nmi event pulses, then sleep and idle levels
	always_ff @(posedge ref_clk_i)
	begin
		evt_o.wdt_timeout <= rst_b_i && kick_i && kind_i == 3'h0;
		evt_o.dmt_timeout <= rst_b_i && kick_i && kind_i == 3'h1;
		evt_o.clock_fail <= rst_b_i && kick_i && kind_i == 3'h2;
		evt_o.clk_switch_done <= rst_b_i && kick_i && kind_i == 3'h3;
		evt_o.general_nmi_flag_event <= rst_b_i && kick_i && kind_i == 3'h4;
		evt_o.in_sleep <= sleep_i;
		evt_o.in_idle <= idle_i;
		// brown-out and config are slow levels, so no extra hold logic
		bor_o <= bor_i;
		cfg_o <= cfg_i;
	end
endmodule

`default_nettype wire

// *** test/tb_top.sv ***
// self-checking bench for the reset status and nmi block
// assumes the far-side model makes the events; the bench plays software
`default_nettype none

module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import rsn_pkg::*;
	logic ref_clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic [7:0] adr = 8'h00;
	logic rd_en = 1'b0;
	logic wr_en = 1'b0;
	logic [31:0] wdat = 32'h0000_0000;
	logic [31:0] rdat, rdq;
	logic wreq, nmi, srst, stby, bor_s;
	logic kick = 1'b0;
	logic [2:0] kind = 3'h0;
	logic slp = 1'b0, idl = 1'b0, bor = 1'b0;
	logic [1:0] cfg = 2'h0;
	logic [1:0] cfg_s;
	rsn_evt_s evt;
	logic [31:0] lfsr = 32'h6CAB;
	int mismatches = 0, total_checks = 0, nmi_cnt = 0, rst_cnt = 0;
	int r, d0, d1, d2, k, n, b;
	int bits[6] = '{25, 24, 23, 19, 17, 16};

	always #50 ref_clk_i = ~ref_clk_i;

	always @(posedge ref_clk_i)
	begin
		nmi_cnt += (nmi === 1'b1);
		rst_cnt += (srst === 1'b1);
	end

	rsn_reset_status rsn_reset_status_i (.ref_clk_i(ref_clk_i),
		.rst_b_i(rst_b_i), .ce_i(1'b1), .avs_address_i(adr),
		.avs_read_i(rd_en), .avs_write_i(wr_en), .avs_writedata_i(wdat),
		.avs_byteenable_i(4'hF), .avs_readdata_o(rdat),
		.avs_waitrequest_o(wreq), .evt_i(evt), .bor_event_i(bor_s),
		.clock_monitor_config_i(cfg_s), .nmi_req_o(nmi),
		.sysrst_req_o(srst), .regulator_standby_o(stby));

	rsn_far_model rsn_far_model_i (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
		.kick_i(kick), .kind_i(kind), .sleep_i(slp), .idle_i(idl),
		.bor_i(bor), .cfg_i(cfg), .evt_o(evt), .bor_o(bor_s), .cfg_o(cfg_s));

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	task finish_test;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	function automatic logic [31:0] lfsr_next(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction

	task chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[ERR] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	// request held until waitrequest is sampled low
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge ref_clk_i);
		adr <= a;
		wdat <= d;
		wr_en <= w;
		rd_en <= !w;
		for (i = 0; i < 20; i++)
		begin
			@(posedge ref_clk_i);
			if (wreq === 1'b0)
				break;
		end
		rdq = rdat;
		wr_en <= 1'b0;
		rd_en <= 1'b0;
		if (i == 20)
		begin
			mismatches++;
			finish_test;
		end
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask

	task rd(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0000_0000);
		chk(rdq, exp);
	endtask

	task ev(input logic [2:0] t);
		@(posedge ref_clk_i);
		kick <= 1'b1;
		kind <= t;
		@(posedge ref_clk_i);
		kick <= 1'b0;
		repeat (4) @(posedge ref_clk_i);
	endtask

	// cycles from the event kick to the system reset request; polling
	// starts before the event lands so a zero reload pulse is not missed
	task delay_of(input logic [2:0] t, input int nval, output int d);
		wr(RSN_OFS_NMI, nval);
		@(posedge ref_clk_i);
		kick <= 1'b1;
		kind <= t;
		@(posedge ref_clk_i);
		kick <= 1'b0;
		for (d = 0; d < 200; d++)
		begin
			@(posedge ref_clk_i);
			if (srst === 1'b1)
				break;
		end
		if (d == 200)
		begin
			mismatches++;
			finish_test;
		end
		repeat (4) @(posedge ref_clk_i);
	endtask

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial
	begin
		repeat (8) @(posedge ref_clk_i);
		rst_b_i <= 1'b1;
		rd(RSN_OFS_CAUSE, RSN_CAUSE_RST);
		rd(RSN_OFS_NMI, RSN_ZERO);
		rd(RSN_OFS_SOFT_RESET_ARM, RSN_ZERO);
		rd(RSN_OFS_PWR, RSN_ZERO);
		rd(8'h44, RSN_ZERO);
		wr(RSN_OFS_CAUSE, RSN_ZERO);
		rd(RSN_OFS_CAUSE, RSN_ZERO);
		$display("test reset_values done");
		slp <= 1'b1;
		repeat (4) @(posedge ref_clk_i);
		chk(stby, 1'b1);
		k = nmi_cnt;
		n = rst_cnt;
		ev(3'h0);
		repeat (30) @(posedge ref_clk_i);
		chk(nmi_cnt - k, 1);
		chk(rst_cnt - n, 0);
		rd(RSN_OFS_CAUSE, 32'h0000_0018);
		rd(RSN_OFS_NMI, 32'h0001_0000);
		wr(RSN_OFS_PWR, 32'hFFFF_FFFF);
		repeat (3) @(posedge ref_clk_i);
		chk(stby, 1'b0);
		rd(RSN_OFS_PWR, RSN_PWR_MASK);
		slp <= 1'b0;
		wr(RSN_OFS_CAUSE, RSN_ZERO);
		idl <= 1'b1;
		repeat (4) @(posedge ref_clk_i);
		idl <= 1'b0;
		rd(RSN_OFS_CAUSE, 32'h0000_0004);
		wr(RSN_OFS_CAUSE, RSN_ZERO);
		bor <= 1'b1;
		repeat (5) @(posedge ref_clk_i);
		bor <= 1'b0;
		repeat (5) @(posedge ref_clk_i);
		rd(RSN_OFS_CAUSE, 32'h0000_0002);
		$display("test cause_flags done");
		wr(RSN_OFS_CAUSE, RSN_ZERO);
		lfsr = lfsr_next(lfsr);
		r = 1 + (lfsr & 7);
		delay_of(3'h1, 0, d0);
		delay_of(3'h1, r, d1);
		chk(d1 - d0, r);
		delay_of(3'h0, r + 3, d2);
		chk(d2 - d1, 3);
		rd(RSN_OFS_CAUSE, 32'h0000_0030);
		rd(RSN_OFS_NMI, 32'h0100_0000 | (r + 3));
		$display("test nmi_counter done");
		for (int i = 0; i < 6; i++)
		begin
			b = bits[i];
			k = nmi_cnt;
			n = rst_cnt;
			wr(RSN_OFS_NMI, (32'h1 << b) | 32'h2);
			repeat (20) @(posedge ref_clk_i);
			chk(nmi_cnt - k, 1);
			chk(rst_cnt - n, b >= 24);
			rd(RSN_OFS_NMI, (32'h1 << b) | 32'h2);
		end
		wr(RSN_OFS_NMI, 32'hFC00_1234);
		rd(RSN_OFS_NMI, 32'h0000_1234);
		k = nmi_cnt;
		wr(RSN_OFS_KEY, 32'h4D00_0000);
		wr(RSN_OFS_KEY, {RSN_NMI_KEY, 24'h00_0000});
		repeat (4) @(posedge ref_clk_i);
		chk(nmi_cnt - k, 1);
		rd(RSN_OFS_NMI, 32'h0008_1234);
		rd(RSN_OFS_KEY, RSN_ZERO);
		wr(RSN_OFS_NMI, RSN_ZERO);
		ev(3'h4);
		rd(RSN_OFS_NMI, 32'h0008_0000);
		wr(RSN_OFS_NMI, RSN_ZERO);
		ev(3'h2);
		rd(RSN_OFS_NMI, RSN_ZERO);
		cfg <= RSN_CLOCK_FAIL_MONITOR_ON;
		repeat (5) @(posedge ref_clk_i);
		k = nmi_cnt;
		n = rst_cnt;
		ev(3'h2);
		chk(nmi_cnt - k, 1);
		rd(RSN_OFS_NMI, 32'h0002_0000);
		ev(3'h3);
		rd(RSN_OFS_NMI, RSN_ZERO);
		ev(3'h2);
		wr(RSN_OFS_NMI, RSN_ZERO);
		rd(RSN_OFS_NMI, RSN_ZERO);
		chk(rst_cnt - n, 0);
		$display("test nmi_sources done");
		wr(RSN_OFS_SOFT_RESET_ARM, 32'h0000_0001);
		rd(RSN_OFS_SOFT_RESET_ARM, RSN_ZERO);
		repeat (10) @(posedge ref_clk_i);
		chk(rst_cnt - n, 0);
		wr(RSN_OFS_UNLOCK, RSN_UNLOCK_KEY1);
		wr(RSN_OFS_UNLOCK, RSN_UNLOCK_KEY2);
		rd(RSN_OFS_UNLOCK, 32'h0000_0001);
		wr(RSN_OFS_SOFT_RESET_ARM, RSN_ZERO);
		rd(RSN_OFS_SOFT_RESET_ARM, RSN_ZERO);
		repeat (10) @(posedge ref_clk_i);
		chk(rst_cnt - n, 0);
		wr(RSN_OFS_SOFT_RESET_ARM, 32'h0000_0001);
		rd(RSN_OFS_SOFT_RESET_ARM, RSN_ZERO);
		repeat (10) @(posedge ref_clk_i);
		chk(rst_cnt - n, 1);
		rd(RSN_OFS_SOFT_RESET_ARM, RSN_ZERO);
		repeat (10) @(posedge ref_clk_i);
		chk(rst_cnt - n, 1);
		rd(RSN_OFS_CAUSE, 32'h0000_0030);
		$display("test soft_reset done");
		finish_test;
	end
endmodule

`default_nettype wire
